// [verilog/ccm_defines.svh]
// offsets, field positions, reset values and sizes of the cycle count monitor
`ifndef CCM_DEFINES_SVH
`define CCM_DEFINES_SVH

// =====================================================================
// sizes
`define CCM_CNT_NUM 18
`define CCM_CNT_W 32
`define CCM_TSC_W 64
`define CCM_ADDR_W 12
`define CCM_DATA_W 32
`define CCM_THREADS 2

// =====================================================================
// register offsets (byte addresses)
`define CCM_CNT_BASE 12'h000
`define CCM_CFG_BASE 12'h100
`define CCM_TSC_LO 12'h200
`define CCM_TSC_HI 12'h204
`define CCM_STAT 12'h208
`define CCM_PAGE_MASK 12'hF00

// =====================================================================
// counter_config_register fields
`define CCM_CFG_EN 0
`define CCM_CFG_CMP 1
`define CCM_CFG_COMPL 2
`define CCM_CFG_THR_LSB 4
`define CCM_CFG_THR_MSB 7
`define CCM_CFG_IEN 8
`define CCM_CFG_OVF 9
`define CCM_CFG_EVS_LSB 12
`define CCM_CFG_EVS_MSB 14
`define CCM_CFG_T0K 16
`define CCM_CFG_T0U 17
`define CCM_CFG_T1K 18
`define CCM_CFG_T1U 19
`define CCM_CFG_WMASK 32'h000F_71F7
`define CCM_CFG_RST 32'h0000_0000

// =====================================================================
// status register fields
`define CCM_STAT_PSAVE 0
`define CCM_STAT_SLEEP 1
`define CCM_STAT_BUSCLK 2
`define CCM_STAT_RUN_LSB 4

`endif

// [verilog/ccm_pkg.sv]
// types of the cycle count monitor
`include "ccm_defines.svh"

package ccm_pkg;

   // =====================================================================
   // event select codes; null event leaves the counter idle
   typedef enum logic [2:0] {
      CCM_EV_NULL,
      CCM_EV_RUNNING,
      CCM_EV_CLOCK
   } ccm_event_t;

   // =====================================================================
   // whole state of the block
   typedef struct packed {
      logic sleep_q1;
      logic sleep_q2;
      logic busclk_q1;
      logic busclk_q2;
      logic [`CCM_CNT_NUM-1:0][`CCM_CNT_W-1:0] cnt;
      logic [`CCM_CNT_NUM-1:0][`CCM_DATA_W-1:0] cfg;
      logic [`CCM_TSC_W-1:0] tsc;
      logic [`CCM_DATA_W-1:0] tsc_hi_snap;
      logic [`CCM_DATA_W-1:0] rdata;
      logic irq;
      logic pkg_psave;
   } ccm_state_t;

endpackage

// [verilog/ccm_cycle_count_monitor.sv]
// cycle counters, time-stamp counter and register port of the cycle count monitor
//
// Behaviour
// - monitor counters stop only when all threads halt
// - time-stamp stops in deep sleep
// - non-halted count per chosen logical processor
// - non-sleep count for whole package
// - counter overflow can raise an interrupt
// - 64-bit time-stamp readable, wraps modulo range
// - time-stamp runs if awake or bus clock
// - per-thread kernel and user qualifier bits
// - eighteen general counters, any usable
// - threshold 15 complement 1 counts every cycle
// - always-true threshold ignores qualifiers
// - package power-saves when all threads halted
// - non-sleep count runs while one thread runs
// - halt transition cycles may be counted
// - time-stamp continues while monitors powered down
// - two logical processors per package
`timescale 1ns/1ps
`default_nettype none
`include "ccm_defines.svh"

module ccm_cycle_count_monitor
   import ccm_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic [`CCM_ADDR_W-1:0] addr,
   input wire logic [`CCM_DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [`CCM_DATA_W-1:0] rdata,
   input wire logic ht_enable,
   input wire logic [`CCM_THREADS-1:0] thread_halted,
   input wire logic [`CCM_THREADS-1:0] thread_psave,
   input wire logic [`CCM_THREADS-1:0] thread_kernel,
   input wire logic sleep_pin,
   input wire logic bus_clk_active,
   output logic pkg_psave,
   output logic irq
);

   // =====================================================================
   // functions

   // register index of a counter or config word, valid flag on top
   function automatic logic [5:0] ccm_index(input logic [`CCM_ADDR_W-1:0] a,
                                            input logic [`CCM_ADDR_W-1:0] base);
      logic [4:0] idx;
      logic ok;
      idx = a[6:2];
      ok = ((a & `CCM_PAGE_MASK) == base) && (a[7] == 1'b0) && (a[1:0] == 2'h0)
           && (idx < 5'(`CCM_CNT_NUM));
      return {ok, idx};
   endfunction

   // qualified running-thread events, or 1 for the clock event, this cycle, 0 to 2
   function automatic logic [1:0] ccm_events(input logic [`CCM_DATA_W-1:0] c,
                                             input logic [`CCM_THREADS-1:0] run,
                                             input logic [`CCM_THREADS-1:0] krn);
      logic q0;
      logic q1;
      logic [1:0] n;
      q0 = 1'b0;
      q1 = 1'b0;
      n = 2'h0;
      case (ccm_event_t'(c[`CCM_CFG_EVS_MSB:`CCM_CFG_EVS_LSB]))
         CCM_EV_RUNNING: begin
            // qualifier bits pick thread and privilege
            q0 = krn[0] ? c[`CCM_CFG_T0K] : c[`CCM_CFG_T0U];
            q1 = krn[1] ? c[`CCM_CFG_T1K] : c[`CCM_CFG_T1U];
            n = {1'b0, run[0] & q0} + {1'b0, run[1] & q1};
         end
         CCM_EV_CLOCK: begin
            n = 2'h1;
         end
         default: begin
            n = 2'h0;
         end
      endcase
      return n;
   endfunction

   // amount a counter advances: raw event count or threshold outcome
   function automatic logic [1:0] ccm_step(input logic [`CCM_DATA_W-1:0] c,
                                           input logic [1:0] ev);
      logic [3:0] thr;
      logic hit;
      thr = c[`CCM_CFG_THR_MSB:`CCM_CFG_THR_LSB];
      hit = c[`CCM_CFG_COMPL] ? ({2'h0, ev} <= thr) : ({2'h0, ev} > thr);
      if (!c[`CCM_CFG_EN]) begin
         return 2'h0;
      end
      // a null event keeps the counter disabled
      if (ccm_event_t'(c[`CCM_CFG_EVS_MSB:`CCM_CFG_EVS_LSB]) == CCM_EV_NULL) begin
         return 2'h0;
      end
      if (c[`CCM_CFG_CMP]) begin
         return {1'b0, hit};
      end
      return ev;
   endfunction

   // =====================================================================
   // state

   ccm_state_t s_r;
   ccm_state_t s_nxt;
   logic [`CCM_THREADS-1:0] run;
   logic all_halted;
   logic tsc_run;
   logic [5:0] wcnt;
   logic [5:0] wcfg;
   logic [5:0] rcnt;
   logic [5:0] rcfg;

   always_comb begin
      s_nxt = s_r;
      // two-stage synchronisers for the pins
      s_nxt.sleep_q1 = sleep_pin;
      s_nxt.sleep_q2 = s_r.sleep_q1;
      s_nxt.busclk_q1 = bus_clk_active;
      s_nxt.busclk_q2 = s_r.busclk_q1;

      // two threads
      // thread 1 only exists with multithreading on
      // running thread
      // halt entry counts
      // the core raises halted only once the halt has completed, so the
      // transition cycles still count as running
      run[0] = !thread_halted[0] && !thread_psave[0];
      run[1] = ht_enable && !thread_halted[1] && !thread_psave[1];

      all_halted = ht_enable ? (&thread_halted) : thread_halted[0];
      s_nxt.pkg_psave = all_halted;

      tsc_run = !s_r.sleep_q2 || s_r.busclk_q2;
      if (tsc_run) begin
         s_nxt.tsc = s_r.tsc + `CCM_TSC_W'(1);
      end

      wcnt = ccm_index(addr, `CCM_CNT_BASE);
      wcfg = ccm_index(addr, `CCM_CFG_BASE);
      rcnt = wcnt;
      rcfg = wcfg;

      for (int i = 0; i < `CCM_CNT_NUM; i++) begin
         logic [1:0] st;
         logic [`CCM_CNT_W:0] sum;
         st = 2'h0;
         sum = '0;
         // package-wide gating
         // powered-down monitor hardware freezes every counter
         if (!all_halted) begin
            st = ccm_step(s_r.cfg[i], ccm_events(s_r.cfg[i], run, thread_kernel));
         end
         sum = {1'b0, s_r.cnt[i]} + {{(`CCM_CNT_W-1){1'b0}}, st};
         s_nxt.cnt[i] = sum[`CCM_CNT_W-1:0];
         // software write to a config word; overflow is write-one-to-clear
         if (wr && wcfg[5] && (wcfg[4:0] == 5'(i))) begin
            s_nxt.cfg[i] = (wdata & `CCM_CFG_WMASK) |
                           (s_r.cfg[i] & ~`CCM_CFG_WMASK);
            if (wdata[`CCM_CFG_OVF]) begin
               s_nxt.cfg[i][`CCM_CFG_OVF] = 1'b0;
            end
         end
         // a load beats the increment
         if (wr && wcnt[5] && (wcnt[4:0] == 5'(i))) begin
            s_nxt.cnt[i] = wdata;
         end else if (sum[`CCM_CNT_W]) begin
            // overflow flag
            // set wins over a clear in the same cycle
            s_nxt.cfg[i][`CCM_CFG_OVF] = 1'b1;
         end
      end

      s_nxt.irq = 1'b0;
      for (int i = 0; i < `CCM_CNT_NUM; i++) begin
         if (s_nxt.cfg[i][`CCM_CFG_OVF] && s_nxt.cfg[i][`CCM_CFG_IEN]) begin
            s_nxt.irq = 1'b1;
         end
      end

      // =====================================================================
      // read port; data stand one cycle only
      s_nxt.rdata = '0;
      if (rd) begin
         if (rcnt[5]) begin
            s_nxt.rdata = s_r.cnt[rcnt[4:0]];
         end else if (rcfg[5]) begin
            s_nxt.rdata = s_r.cfg[rcfg[4:0]];
         end else begin
            case (addr)
               `CCM_TSC_LO: begin
                  // read stamp
                  // low half read snapshots the high half so a pair is coherent
                  s_nxt.rdata = s_r.tsc[31:0];
                  s_nxt.tsc_hi_snap = s_r.tsc[63:32];
               end
               `CCM_TSC_HI: begin
                  s_nxt.rdata = s_r.tsc_hi_snap;
               end
               `CCM_STAT: begin
                  s_nxt.rdata[`CCM_STAT_PSAVE] = s_r.pkg_psave;
                  s_nxt.rdata[`CCM_STAT_SLEEP] = s_r.sleep_q2;
                  s_nxt.rdata[`CCM_STAT_BUSCLK] = s_r.busclk_q2;
                  s_nxt.rdata[`CCM_STAT_RUN_LSB+1:`CCM_STAT_RUN_LSB] = run;
               end
               default: begin
                  s_nxt.rdata = '0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign rdata = s_r.rdata;
   assign pkg_psave = s_r.pkg_psave;
   assign irq = s_r.irq;

   // =====================================================================
   // assertions

   logic c0_wr;
   logic c0_always;
   logic [`CCM_DATA_W-1:0] cfg0;
   logic t0_qual;
   assign cfg0 = s_r.cfg[0];
   assign t0_qual = thread_kernel[0] ? cfg0[`CCM_CFG_T0K] : cfg0[`CCM_CFG_T0U];
   assign c0_wr = wr && (addr == `CCM_CNT_BASE);
   assign c0_always = cfg0[`CCM_CFG_EN] && cfg0[`CCM_CFG_CMP] && cfg0[`CCM_CFG_COMPL]
                      && (cfg0[`CCM_CFG_THR_MSB:`CCM_CFG_THR_LSB] == 4'hF)
                      && (cfg0[`CCM_CFG_EVS_MSB:`CCM_CFG_EVS_LSB] != 3'h0);

   // the edge that applies reset leaves no increment to show
   property p_tsc_step;
      @(posedge clock) disable iff (rst)
      !rst && ce && (!s_r.sleep_q2 || s_r.busclk_q2) |=> s_r.tsc == $past(s_r.tsc) + 64'h1;
   endproperty
   a_tsc_step: assert property (p_tsc_step) else $error("stamp did not advance");

   property p_tsc_deep;
      @(posedge clock) disable iff (rst)
      ce && s_r.sleep_q2 && !s_r.busclk_q2 |=> $stable(s_r.tsc);
   endproperty
   a_tsc_deep: assert property (p_tsc_deep) else $error("stamp ran in deep sleep");

   property p_halt_freeze;
      @(posedge clock) disable iff (rst)
      ce && all_halted && !c0_wr |=> $stable(s_r.cnt[0]) && pkg_psave;
   endproperty
   a_halt_freeze: assert property (p_halt_freeze) else $error("counter ran while powered down");

   sequence s_one_runs;
      ce && ht_enable && (thread_halted != 2'h3) && c0_always && !c0_wr;
   endsequence

   property p_one_thread;
      @(posedge clock) disable iff (rst)
      s_one_runs |=> s_r.cnt[0] == $past(s_r.cnt[0]) + 32'h1;
   endproperty
   a_one_thread: assert property (p_one_thread) else $error("non-sleep count stalled");

   sequence s_two_always;
      s_one_runs ##1 s_one_runs;
   endsequence

   property p_every_cycle;
      @(posedge clock) disable iff (rst)
      s_two_always |=> s_r.cnt[0] == $past(s_r.cnt[0], 2) + 32'h2;
   endproperty
   a_every_cycle: assert property (p_every_cycle) else $error("threshold count missed");

   property p_null_event;
      @(posedge clock) disable iff (rst)
      ce && !c0_wr && (cfg0[`CCM_CFG_EVS_MSB:`CCM_CFG_EVS_LSB] == 3'h0) |=> $stable(s_r.cnt[0]);
   endproperty
   a_null_event: assert property (p_null_event) else $error("null event counted");

   property p_qualified;
      @(posedge clock) disable iff (rst)
      ce && !c0_wr && !all_halted && cfg0[`CCM_CFG_EN] && !cfg0[`CCM_CFG_CMP]
      && (cfg0[`CCM_CFG_EVS_MSB:`CCM_CFG_EVS_LSB] == 3'h1)
      && !cfg0[`CCM_CFG_T1K] && !cfg0[`CCM_CFG_T1U]
      |=> s_r.cnt[0] == $past(s_r.cnt[0]) + {31'h0, $past(run[0] && t0_qual)};
   endproperty
   a_qualified: assert property (p_qualified) else $error("non-halted count wrong");

   // another counter may also hold irq high, so only its presence is demanded
   property p_overflow;
      @(posedge clock) disable iff (rst)
      ce && !c0_wr && !all_halted && c0_always && (s_r.cnt[0] == 32'hFFFF_FFFF)
      |=> (s_r.cnt[0] == 32'h0) && s_r.cfg[0][`CCM_CFG_OVF]
          && (!s_r.cfg[0][`CCM_CFG_IEN] || irq);
   endproperty
   a_overflow: assert property (p_overflow) else $error("wrap did not flag overflow");

   property p_read_stamp;
      @(posedge clock) disable iff (rst)
      ce && rd && (addr == `CCM_TSC_LO) |=> rdata == $past(s_r.tsc[31:0]);
   endproperty
   a_read_stamp: assert property (p_read_stamp) else $error("stamp read wrong");

   property p_rdata_idle;
      @(posedge clock) disable iff (rst)
      ce && !rd |=> rdata == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data stood too long");

   property p_psave_follow;
      @(posedge clock) disable iff (rst)
      ce |=> pkg_psave == $past(all_halted);
   endproperty
   a_psave_follow: assert property (p_psave_follow) else $error("power-save flag lagged");

   property p_ce_freeze;
      @(posedge clock) disable iff (rst)
      !ce |=> $stable(s_r.tsc) && $stable(s_r.cnt[0]) && $stable(rdata);
   endproperty
   a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low");

endmodule
`default_nettype wire

// [dv/tb_ccm_cycle_count_monitor.sv]
// self-checking bench for the cycle count monitor
`timescale 1ns/1ps
`default_nettype none

module tb_ccm_cycle_count_monitor;
   // =====================================================================
   // stimulus and observed signals
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic ht_enable = 1'b1;
   logic [1:0] thread_halted = 2'b00;
   logic [1:0] thread_psave = 2'b00;
   logic [1:0] thread_kernel = 2'b11;
   logic sleep_pin = 1'b0;
   logic bus_clk_active = 1'b1;
   logic pkg_psave;
   logic irq;
   int num_errors = 0;
   int comparisons = 0;
   logic [31:0] d;
   // every-cycle count: enable, compare, complement, threshold 15, running event
   localparam logic [31:0] NS = 32'h0000_10F7;

   ccm_cycle_count_monitor dut_u (
      .clock(clock), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .ht_enable(ht_enable), .thread_halted(thread_halted),
      .thread_psave(thread_psave), .thread_kernel(thread_kernel), .sleep_pin(sleep_pin),
      .bus_clk_active(bus_clk_active), .pkg_psave(pkg_psave), .irq(irq)
   );

   initial begin
      forever #5 clock = ~clock;
   end

   // =====================================================================
   // helpers
   task automatic finish_test();
      if (num_errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [11:0] a, output logic [31:0] v);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1 v = rdata;
   endtask

   // two reads n cycles apart; their strobe edges lie n+2 cycles apart
   task automatic span(input logic [11:0] a, input int n, output logic [31:0] dl);
      logic [31:0] x;
      logic [31:0] y;
      rd_reg(a, x);
      repeat (n) @(posedge clock);
      rd_reg(a, y);
      dl = y - x;
   endtask

   // inputs change together, then the pin synchronisers get time to settle
   task automatic setc(input logic h, input logic [1:0] hl, input logic [1:0] ps,
                       input logic [1:0] k, input logic s, input logic b);
      @(posedge clock);
      ht_enable <= h;
      thread_halted <= hl;
      thread_psave <= ps;
      thread_kernel <= k;
      sleep_pin <= s;
      bus_clk_active <= b;
      repeat (4) @(posedge clock);
   endtask

   // =====================================================================
   // scenarios
   task automatic t_reset();
      rd_reg(12'h100, d);
      chk(d, 32'h0000_0000, "config after reset");
      rd_reg(12'h014, d);
      chk(d, 32'h0000_0000, "counter after reset");
      rd_reg(12'h300, d);
      chk(d, 32'h0000_0000, "unmapped read");
      rd_reg(12'h200, d);
      chk({31'h0, d != 32'h0}, 32'h0000_0001, "stamp runs after reset");
      @(posedge clock);
      #1 chk(rdata, 32'h0000_0000, "read data held too long");
   endtask

   task automatic t_nonsleep();
      setc(1'b1, 2'b00, 2'b00, 2'b00, 1'b0, 1'b1);
      for (int i = 0; i < 18; i++) begin
         wr_reg(12'h100 + 12'(4 * i), NS & 32'hFFFF_FFFE);
         wr_reg(12'h100 + 12'(4 * i), NS);
         span(12'(4 * i), 3, d);
         chk(d, 32'h0000_0005, "non-sleep count, user mode");
      end
      wr_reg(12'h104, 32'h0000_00F7);
      span(12'h004, 3, d);
      chk(d, 32'h0000_0000, "null event counted");
      setc(1'b1, 2'b10, 2'b00, 2'b00, 1'b0, 1'b1);
      #1 chk({31'h0, pkg_psave}, 32'h0000_0000, "one thread halted");
      span(12'h000, 3, d);
      chk(d, 32'h0000_0005, "one thread still running");
      setc(1'b1, 2'b11, 2'b00, 2'b00, 1'b0, 1'b1);
      #1 chk({31'h0, pkg_psave}, 32'h0000_0001, "all halted");
      rd_reg(12'h208, d);
      chk(d, 32'h0000_0005, "status while all halted");
      span(12'h000, 3, d);
      chk(d, 32'h0000_0000, "count while powered down");
      span(12'h200, 3, d);
      chk(d, 32'h0000_0005, "stamp while powered down");
      setc(1'b0, 2'b01, 2'b00, 2'b00, 1'b0, 1'b1);
      #1 chk({31'h0, pkg_psave}, 32'h0000_0001, "single thread halted");
   endtask

   task automatic t_halted();
      setc(1'b1, 2'b00, 2'b00, 2'b11, 1'b0, 1'b1);
      wr_reg(12'h100, 32'h0001_1001);
      span(12'h000, 3, d);
      chk(d, 32'h0000_0005, "thread0 kernel");
      setc(1'b1, 2'b00, 2'b00, 2'b10, 1'b0, 1'b1);
      span(12'h000, 3, d);
      chk(d, 32'h0000_0000, "thread0 user masked");
      wr_reg(12'h100, 32'h0005_1001);
      setc(1'b1, 2'b00, 2'b00, 2'b11, 1'b0, 1'b1);
      span(12'h000, 3, d);
      chk(d, 32'h0000_000A, "both threads kernel");
      setc(1'b1, 2'b00, 2'b01, 2'b11, 1'b0, 1'b1);
      span(12'h000, 3, d);
      chk(d, 32'h0000_0005, "thread0 power saving");
      setc(1'b0, 2'b00, 2'b01, 2'b11, 1'b0, 1'b1);
      span(12'h000, 3, d);
      chk(d, 32'h0000_0000, "second thread absent");
   endtask

   task automatic t_stamp();
      setc(1'b1, 2'b00, 2'b00, 2'b11, 1'b1, 1'b1);
      span(12'h200, 3, d);
      chk(d, 32'h0000_0005, "asleep, bus clock running");
      setc(1'b1, 2'b00, 2'b00, 2'b11, 1'b0, 1'b0);
      span(12'h200, 3, d);
      chk(d, 32'h0000_0005, "awake, bus clock stopped");
      setc(1'b1, 2'b00, 2'b00, 2'b11, 1'b1, 1'b0);
      span(12'h200, 3, d);
      chk(d, 32'h0000_0000, "deep sleep");
      rd_reg(12'h204, d);
      chk(d, 32'h0000_0000, "stamp upper half");
      setc(1'b1, 2'b00, 2'b00, 2'b11, 1'b0, 1'b1);
   endtask

   // enable low for four edges; the stamp moves on the three enabled edges between reads
   task automatic t_enable();
      logic [31:0] x;
      rd_reg(12'h200, x);
      @(posedge clock);
      ce <= 1'b0;
      repeat (4) @(posedge clock);
      ce <= 1'b1;
      rd_reg(12'h200, d);
      chk(d - x, 32'h0000_0003, "stamp ran with clock enable low");
   endtask

   task automatic t_wrap();
      wr_reg(12'h100, NS | 32'h0000_0100);
      wr_reg(12'h000, 32'hFFFF_FFFD);
      #1 chk({31'h0, irq}, 32'h0000_0000, "interrupt before wrap");
      repeat (6) @(posedge clock);
      #1 chk({31'h0, irq}, 32'h0000_0001, "interrupt after wrap");
      rd_reg(12'h100, d);
      chk(d & 32'h0000_0200, 32'h0000_0200, "overflow flag");
      rd_reg(12'h000, d);
      chk({31'h0, d < 32'h10}, 32'h0000_0001, "counter wrapped");
      wr_reg(12'h100, NS | 32'h0000_0300);
      repeat (2) @(posedge clock);
      #1 chk({31'h0, irq}, 32'h0000_0000, "interrupt cleared");
   endtask

   // =====================================================================
   // main sequence and watchdog
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      t_reset();
      t_nonsleep();
      t_halted();
      t_stamp();
      t_enable();
      t_wrap();
      finish_test();
   end

   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      finish_test();
   end
endmodule

`default_nettype wire
